/* File: verilog/ssf_map.vh */
`ifndef SSF_MAP_VH
`define SSF_MAP_VH
`define SSF_ADDR_STATUS 4'h0
`define SSF_ADDR_TICKCFG 4'h4
`define SSF_SUB_LSB 16
`define SSF_SUB_MSB 21
`define SSF_URX_BIT 22
`define SSF_UTX_BIT 23
`define SSF_CRX_BIT 24
`define SSF_CTX_BIT 25
`define SSF_SSI_BIT 26
`define SSF_BOOT_LSB 27
`define SSF_BOOT_MSB 28
`define SSF_VER_LSB 30
`define SSF_VER_MSB 31
`define SSF_TICK_HZ 64
`define SSF_CLK_HZ 100000000
`define SSF_TICK_CYC (`SSF_CLK_HZ / `SSF_TICK_HZ)
`define SSF_BOOT_32 2'h0
`define SSF_BOOT_8 2'h1
`define SSF_BOOT_16 2'h2
`define SSF_BOOT_RSVD 2'h3
`endif

/* File: verilog/ssf_tick_div.v */
`timescale 1ns/1ps
`include "ssf_map.vh"
module ssf_tick_div #(
  parameter TICK_CYC = `SSF_TICK_CYC
) (
  input wire clk_i,
  input wire rst_i,
  output reg tick_o
);
  reg [31:0] cnt_q;
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 32'h0;
      tick_o <= 1'b0;
    end else if (cnt_q == TICK_CYC - 1) begin
      cnt_q <= 32'h0;
      tick_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick_o <= 1'b0;
    end
  end
endmodule // ssf_tick_div

/* File: verilog/ssf_subsec_chain.v */
`timescale 1ns/1ps
module ssf_subsec_chain #(
  parameter STAGES = 6
) (
  input wire clk_i,
  input wire rst_i,
  input wire tick_i,
  output reg [STAGES-1:0] count_o,
  output wire second_o
);
  // stage k toggles when all faster stages are high; stage 0 is fastest
  wire [STAGES:0] carry;
  assign carry[0] = tick_i;
  genvar k;
  generate
    for (k = 0; k < STAGES; k = k + 1) begin : g_stage
      assign carry[k+1] = carry[k] & count_o[k];
    end
  endgenerate
  // one process owns the whole count so each bit has a single driver
  always @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= {STAGES{1'b0}};
    end else begin
      count_o <= count_o ^ carry[STAGES-1:0];
    end
  end
  assign second_o = carry[STAGES];
endmodule // ssf_subsec_chain

/* File: verilog/ssf_status.v */
// Overview of operation
// - bits 21:16 count 64 Hz ticks since the last rtc increment.
// - in that count the msb is the 32 Hz stage, the lsb the 1 Hz one.
// - bit 22 is set when uart1 has no received data, per its fifo mode.
// - bit 23 is set when uart1 cannot take tx data, per its fifo mode.
// - bit 24 is set while the codec receive fifo is empty.
// - bit 25 is set while the codec transmit fifo is full.
// - bit 26 is high while the serial interface shifts and low when idle.
// - boot-width bits keep port e lines 0 and 1 from power-on reset.
// - straps both low mean 32-bit boot, low strap alone 8-bit, high strap alone 16-bit.
// - bits 31:30 return a fixed two-bit silicon version.
// - the status word is read-only and writes change no field.
`timescale 1ns/1ps
`include "ssf_map.vh"
module ssf_status #(
  parameter TICK_CYC = `SSF_TICK_CYC,
  // arbitrary neutral version value
  parameter [1:0] VERSION = 2'h1
) (
  input wire clk_i,
  input wire rst_i,
  input wire [3:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output wire wb_err_o,
  input wire uart_fifo_mode_enable_i,
  input wire uart1_rx_hold_empty_i,
  input wire uart1_rx_fifo_empty_i,
  input wire uart1_tx_hold_full_i,
  input wire uart1_tx_fifo_full_i,
  input wire codec_rx_fifo_empty_i,
  input wire codec_tx_fifo_full_i,
  input wire serial_shift_active_i,
  input wire boot_width_strap_low_i,
  input wire boot_width_strap_high_i,
  output reg [1:0] boot_width_code_o,
  output wire rtc_second_o
);
  wire tick_raw;
  wire tick_en;
  wire [5:0] sub_cnt;
  reg tick_gate_q;
  reg boot_low_q;
  reg boot_high_q;
  reg por_seen_q;
  reg [31:0] word;
  wire req;

  ssf_tick_div #(.TICK_CYC(TICK_CYC)) u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(tick_raw)
  );

  // software may halt the divider chain through the extra control word
  assign tick_en = tick_raw & tick_gate_q;

  ssf_subsec_chain #(.STAGES(6)) u_chain (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick_en),
    .count_o(sub_cnt),
    .second_o(rtc_second_o)
  );

  // straps caught on the first edge after reset releases, kept until the next reset
  always @(posedge clk_i) begin
    if (rst_i) begin
      por_seen_q <= 1'b1;
    end else begin
      por_seen_q <= 1'b0;
    end
  end

  always @(posedge clk_i) begin
    if (por_seen_q) begin
      boot_low_q <= boot_width_strap_low_i;
      boot_high_q <= boot_width_strap_high_i;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      boot_width_code_o <= `SSF_BOOT_32;
    end else begin
      case ({boot_high_q, boot_low_q})
        2'h0: boot_width_code_o <= `SSF_BOOT_32;
        2'h1: boot_width_code_o <= `SSF_BOOT_8;
        2'h2: boot_width_code_o <= `SSF_BOOT_16;
        default: boot_width_code_o <= `SSF_BOOT_RSVD;
      endcase
    end
  end

  always @* begin
    word = 32'h0;
    // count bit 0 is the fastest stage, shown as the msb
    word[`SSF_SUB_MSB:`SSF_SUB_LSB] = {sub_cnt[0], sub_cnt[1], sub_cnt[2],
      sub_cnt[3], sub_cnt[4], sub_cnt[5]};
    word[`SSF_URX_BIT] = uart_fifo_mode_enable_i ? uart1_rx_fifo_empty_i :
      uart1_rx_hold_empty_i;
    word[`SSF_UTX_BIT] = uart_fifo_mode_enable_i ? uart1_tx_fifo_full_i :
      uart1_tx_hold_full_i;
    word[`SSF_CRX_BIT] = codec_rx_fifo_empty_i;
    word[`SSF_CTX_BIT] = codec_tx_fifo_full_i;
    word[`SSF_SSI_BIT] = serial_shift_active_i;
    word[`SSF_BOOT_LSB] = boot_low_q;
    word[`SSF_BOOT_MSB] = boot_high_q;
    word[`SSF_VER_MSB:`SSF_VER_LSB] = VERSION;
  end

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_err_o = 1'b0;

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      tick_gate_q <= 1'b1;
    end else begin
      wb_ack_o <= req;
      if (req & ~wb_we_i) begin
        case (wb_adr_i)
          `SSF_ADDR_STATUS: wb_dat_o <= word;
          `SSF_ADDR_TICKCFG: wb_dat_o <= {31'h0, tick_gate_q};
          default: wb_dat_o <= 32'h0;
        endcase
      end
      // status word ignores writes; only the tick gate is writable
      if (req & wb_we_i & wb_sel_i[0] &
          (wb_adr_i == `SSF_ADDR_TICKCFG)) begin
        tick_gate_q <= wb_dat_i[0];
      end
    end
  end
endmodule // ssf_status

/* File: test/ssf_status_monitor.sv */
`timescale 1ns/1ps
module ssf_chk (
  input wire clk_i,
  input wire rst_i,
  input wire [3:0] wb_adr_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire codec_rx_fifo_empty_i,
  input wire [1:0] boot_width_code_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a request needs cyc and stb with no ack still pending
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_rd; s_req ##0 !wb_we_i && wb_adr_i == 4'h0; endsequence
  AST_ACK: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack");
  AST_NOREQ: assert property (wb_ack_o |-> $past(wb_stb_i))
    else $error("stray ack");
  AST_HOLD: assert property (!wb_stb_i |=> $stable(wb_dat_o))
    else $error("dat moved");
  AST_WRO: assert property (s_req ##0 wb_we_i |=> $stable(wb_dat_o))
    else $error("write moved dat");
  AST_UNMAP: assert property (s_req ##0 !wb_we_i && wb_adr_i[3] |=>
    wb_dat_o == 32'h0) else $error("unmapped");
  AST_CRX: assert property (s_rd |=>
    wb_dat_o[24] == $past(codec_rx_fifo_empty_i)) else $error("bit 24");
  AST_BOOT: assert property (s_rd |=>
    wb_dat_o[28:27] == boot_width_code_o) else $error("boot");
  AST_VER: assert property (s_rd |=> wb_dat_o[31:29] == 3'h2)
    else $error("version");
endmodule // ssf_chk
bind ssf_status ssf_chk u_chk (.*);

/* File: test/ssf_status_tb_top.sv */
`timescale 1ns/1ps
module ssf_status_tb_top;
  reg clk = 0, rst = 1, cyc = 0, we = 0;
  reg [3:0] adr = 4'h0;
  reg [31:0] wd = 32'h0, v;
  reg [7:0] f = 8'h0;
  reg [1:0] bs = 2'h0;
  wire [31:0] rd;
  wire [1:0] code;
  wire ack, sec, err;
  integer error_cnt = 0, n_tests = 0, i;
  always #5 clk = ~clk;
  // short tick period keeps a full wrap of the chain near 512 cycles
  ssf_status #(.TICK_CYC(8)) dut (.clk_i(clk), .rst_i(rst),
    .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(4'hF), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(rd), .wb_ack_o(ack),
    .wb_err_o(err), .uart_fifo_mode_enable_i(f[0]),
    .uart1_rx_hold_empty_i(f[1]), .uart1_rx_fifo_empty_i(f[2]),
    .uart1_tx_hold_full_i(f[3]), .uart1_tx_fifo_full_i(f[4]),
    .codec_rx_fifo_empty_i(f[5]), .codec_tx_fifo_full_i(f[6]),
    .serial_shift_active_i(f[7]), .boot_width_strap_low_i(bs[0]),
    .boot_width_strap_high_i(bs[1]), .boot_width_code_o(code),
    .rtc_second_o(sec));
  task complete_run;
    begin
      $display("errors %0d of %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task chk(input [31:0] n, input [31:0] x, input [31:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== x) begin
        error_cnt = error_cnt + 1;
        $display("Error %s exp %h got %h", n, x, g);
      end
    end
  endtask
  task bus(input w, input [3:0] a, input [31:0] d);
    begin
      {cyc, we, adr, wd} <= {1'b1, w, a, d};
      do @(posedge clk); while (ack !== 1'b1);
      v = rd;
      cyc <= 0;
      @(posedge clk);
    end
  endtask
  task t_boot;
    for (i = 0; i < 4; i = i + 1) begin
      {rst, bs} <= {1'b1, i[1:0]};
      repeat (8) @(posedge clk);
      rst <= 0;
      repeat (3) @(posedge clk);
      // straps move after the latch window and must not show
      bs <= ~i[1:0];
      bus(1, 4'h0, 32'hFFFFFFFF);
      bus(0, 4'h8, 32'h0);
      bus(0, 4'h0, 32'h0);
      chk("boot", i, v[28:27]);
      chk("ver", 2, v[31:29]);
      chk("code", i, code);
      chk("err", 32'h0, err);
    end
  endtask
  // the tick gate must freeze the chain, which reset leaves at zero
  task t_gate;
    begin
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      bus(0, 4'h4, 32'h0);
      chk("gate", 32'h1, v);
      bus(1, 4'h4, 32'h0);
      repeat (100) @(posedge clk);
      bus(0, 4'h0, 32'h0);
      chk("frz", 32'h0, v[21:16]);
      bus(1, 4'h4, 32'h1);
      bus(0, 4'h4, 32'h0);
      chk("gate", 32'h1, v);
    end
  endtask
  task t_flags;
    for (i = 0; i < 256; i = i + 1) begin
      f <= i[7:0];
      bus(0, 4'h0, 32'h0);
      chk("flag", {i[7:5], i[0] ? i[4] : i[3], i[0] ? i[2] : i[1]},
        v[26:22]);
    end
  endtask
  task t_sub;
    begin
      while (sec !== 1'b1) @(posedge clk);
      bus(0, 4'h0, 32'h0);
      chk("sub0", 0, v[21:16]);
      repeat (6) @(posedge clk);
      bus(0, 4'h0, 32'h0);
      chk("sub1", 6'h20, v[21:16]);
    end
  endtask
  initial begin
    t_boot;
    t_flags;
    t_gate;
    t_sub;
    complete_run;
  end
  initial begin
    #100000;
    error_cnt = error_cnt + 1;
    complete_run;
  end
endmodule // ssf_status_tb_top
